// File: src/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [11:0] ADDR_CHANNEL_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_CLOCK_CONFIG    = 12'h004;
  localparam logic [11:0] ADDR_RESULT_HIGH     = 12'h008;
  localparam logic [11:0] ADDR_RESULT_LOW      = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_STATUS      = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK        = 12'h014;
  // ****************************************
  // field positions
  // ****************************************
  localparam int ENABLE_BIT   = 0;
  localparam int GO_BIT       = 1;
  localparam int CHS_LSB      = 2;
  localparam int CHS_MSB      = 6;
  localparam int CLKSEL_LSB   = 4;
  localparam int CLKSEL_MSB   = 6;
  localparam int DONE_IRQ_BIT = 0;
  // ****************************************
  // clock select codes and dividers
  // ****************************************
  localparam logic [2:0] CLKSEL_DIV8  = 3'h1;
  localparam logic [2:0] CLKSEL_DIV16 = 3'h5;
  localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
  localparam logic [2:0] CLKSEL_DIV64 = 3'h6;
  localparam logic [1:0] CLKSEL_RC_LO = 2'h3;
  localparam logic [6:0] DIV8  = 7'h08;
  localparam logic [6:0] DIV16 = 7'h10;
  localparam logic [6:0] DIV32 = 7'h20;
  localparam logic [6:0] DIV64 = 7'h40;
  localparam logic [4:0] RC_DIV = 5'h10;
  // ****************************************
  // channel codes
  // ****************************************
  localparam logic [4:0] CHS_RSV_A   = 5'h08;
  localparam logic [4:0] CHS_RSV_B   = 5'h09;
  localparam logic [1:0] CHS_GRP_INT = 2'h0;
  localparam logic [1:0] CHS_GRP_INT2 = 2'h1;
  localparam logic [1:0] CHS_GRP_PIN = 2'h3;
  // ****************************************
  // conversion timing in conversion clocks
  // ****************************************
  localparam logic [3:0] CONV_TADS  = 4'hb;
  localparam logic [1:0] ABORT_TADS = 2'h2;
  localparam int RESULT_W = 10;
endpackage : adc_ctrl_pkg
`default_nettype wire

// File: src/adc_clock_divider.sv
`default_nettype none
// ****************************************
// conversion clock enable generator
// ****************************************
module adc_clock_divider (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // control
  input  wire logic       run,
  input  wire logic [6:0] divide,
  // enable out
  output logic            tick
);
  logic [6:0] count_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 7'h00;
    end else if (!run || tick) begin
      count_q <= 7'h00;
    end else begin
      count_q <= count_q + 7'h01;
    end
  end

  // >= so a smaller divide picked in mid-count cannot wrap the counter
  assign tick = run && (count_q >= divide - 7'h01);
endmodule : adc_clock_divider
`default_nettype wire

// File: src/adc_conversion_control.sv
`default_nettype none
module adc_conversion_control #(
  parameter int RESULT_W = adc_ctrl_pkg::RESULT_W
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic      [31:0]         prdata,
  // internal rc oscillator enable, one pulse per oscillator period
  input  wire logic                rcOscTick,
  // analog front end
  output logic                     converterPower,
  output logic      [4:0]          channelSelect,
  output logic                     channelValid,
  output logic                     sampleHold,
  output logic                     bitTrial,
  output logic      [3:0]          bitIndex,
  input  wire logic                comparatorHigh,
  // interrupt
  output logic                     irq
);
  // ****************************************
  // state encoding
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_CONVERT = 4'b0010,
    ST_ABORT   = 4'b0100,
    ST_DONE    = 4'b1000
  } conv_state_e;

  conv_state_e          state_q;
  logic [4:0]           chanSel_q;
  logic                 goBusy_q;
  logic                 enable_q;
  logic [2:0]           clkSel_q;
  logic [RESULT_W-1:0]  result_q;
  logic [RESULT_W-1:0]  sar_q;
  logic [3:0]           tadCount_q;
  logic [1:0]           abortCount_q;
  logic                 doneFlag_q;
  logic                 doneMask_q;
  logic [4:0]           rcCount_q;
  logic                 rcTick;
  logic                 sysTick;
  logic                 tadTick;
  logic                 divRun;
  logic [6:0]           divValue;
  logic                 wrEn;
  logic                 rdEn;
  logic                 convEnd;
  logic                 swClearGo;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [6:0] divOf(input logic [2:0] sel);
    case (sel)
      adc_ctrl_pkg::CLKSEL_DIV8:  divOf = adc_ctrl_pkg::DIV8;
      adc_ctrl_pkg::CLKSEL_DIV16: divOf = adc_ctrl_pkg::DIV16;
      adc_ctrl_pkg::CLKSEL_DIV32: divOf = adc_ctrl_pkg::DIV32;
      adc_ctrl_pkg::CLKSEL_DIV64: divOf = adc_ctrl_pkg::DIV64;
      default:                    divOf = 7'h00;
    endcase
  endfunction : divOf

  function automatic logic chanOk(input logic [4:0] c);
    logic [1:0] grp;
    grp = c[4:3];
    chanOk = 1'b0;
    if (grp == adc_ctrl_pkg::CHS_GRP_PIN) begin
      chanOk = 1'b1;
    end else if (grp == adc_ctrl_pkg::CHS_GRP_INT ||
                 grp == adc_ctrl_pkg::CHS_GRP_INT2) begin
      chanOk = (c != adc_ctrl_pkg::CHS_RSV_A) &&
               (c != adc_ctrl_pkg::CHS_RSV_B);
    end
  endfunction : chanOk

  // ****************************************
  // bus decode
  // ****************************************
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  // unmapped addresses answer with an error rather than silently
  assign pslverr = psel && penable &&
                   !(paddr == adc_ctrl_pkg::ADDR_CHANNEL_CONTROL ||
                     paddr == adc_ctrl_pkg::ADDR_CLOCK_CONFIG ||
                     paddr == adc_ctrl_pkg::ADDR_RESULT_HIGH ||
                     paddr == adc_ctrl_pkg::ADDR_RESULT_LOW ||
                     paddr == adc_ctrl_pkg::ADDR_IRQ_STATUS ||
                     paddr == adc_ctrl_pkg::ADDR_IRQ_MASK);

  assign swClearGo = wrEn && goBusy_q &&
                     paddr == adc_ctrl_pkg::ADDR_CHANNEL_CONTROL &&
                     !pwdata[adc_ctrl_pkg::GO_BIT];

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chanSel_q <= 5'h00;
      enable_q  <= 1'b0;
      clkSel_q  <= 3'h0;
      doneMask_q <= 1'b0;
    end else if (wrEn) begin
      case (paddr)
        adc_ctrl_pkg::ADDR_CHANNEL_CONTROL: begin
          chanSel_q <= pwdata[adc_ctrl_pkg::CHS_MSB:adc_ctrl_pkg::CHS_LSB];
          enable_q  <= pwdata[adc_ctrl_pkg::ENABLE_BIT];
        end
        adc_ctrl_pkg::ADDR_CLOCK_CONFIG: begin
          clkSel_q <=
            pwdata[adc_ctrl_pkg::CLKSEL_MSB:adc_ctrl_pkg::CLKSEL_LSB];
        end
        adc_ctrl_pkg::ADDR_IRQ_MASK: begin
          doneMask_q <= pwdata[adc_ctrl_pkg::DONE_IRQ_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // conversion clock
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rcCount_q <= 5'h00;
    end else if (!enable_q) begin
      rcCount_q <= 5'h00;
    end else if (rcOscTick) begin
      rcCount_q <= (rcCount_q == adc_ctrl_pkg::RC_DIV - 5'h01) ?
                   5'h00 : rcCount_q + 5'h01;
    end
  end
  assign rcTick = rcOscTick && (rcCount_q == adc_ctrl_pkg::RC_DIV - 5'h01);

  assign divValue = divOf(clkSel_q);
  assign divRun   = enable_q && (divValue != 7'h00);

  adc_clock_divider u_div (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .run     (divRun),
    .divide  (divValue),
    .tick    (sysTick)
  );

  // reserved clock codes give no conversion clock, so a start just stalls
  assign tadTick = (clkSel_q[1:0] == adc_ctrl_pkg::CLKSEL_RC_LO) ?
                   rcTick : sysTick;

  // ****************************************
  // conversion sequencer
  // ****************************************
  // an abort in the completing cycle wins, so the old result stays
  assign convEnd = (state_q == ST_CONVERT) && enable_q && !swClearGo &&
                   tadTick &&
                   (tadCount_q == adc_ctrl_pkg::CONV_TADS - 4'h1);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q      <= ST_IDLE;
      tadCount_q   <= 4'h0;
      abortCount_q <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          tadCount_q <= 4'h0;
          if (goBusy_q && enable_q) begin
            state_q <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (!enable_q || swClearGo) begin
            state_q      <= ST_ABORT;
            abortCount_q <= 2'h0;
          end else if (convEnd) begin
            state_q <= ST_DONE;
          end else if (tadTick) begin
            tadCount_q <= tadCount_q + 4'h1;
          end
        end
        ST_ABORT: begin
          if (!enable_q) begin
            state_q <= ST_IDLE;
          end else if (tadTick) begin
            if (abortCount_q == adc_ctrl_pkg::ABORT_TADS - 2'h1) begin
              state_q <= ST_IDLE;
            end else begin
              abortCount_q <= abortCount_q + 2'h1;
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // go bit: set by software, cleared by hardware at end or by software
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      goBusy_q <= 1'b0;
    end else if (convEnd || !enable_q) begin
      goBusy_q <= 1'b0;
    end else if (wrEn && paddr == adc_ctrl_pkg::ADDR_CHANNEL_CONTROL) begin
      // a start is refused while the abort gap is still running
      goBusy_q <= pwdata[adc_ctrl_pkg::GO_BIT] &&
                  pwdata[adc_ctrl_pkg::ENABLE_BIT] &&
                  (state_q != ST_ABORT);
    end
  end

  // successive approximation, msb first, one bit per conversion clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sar_q <= '0;
    end else if (state_q == ST_IDLE) begin
      sar_q <= '0;
    end else if (state_q == ST_CONVERT && tadTick &&
                 tadCount_q != 4'h0 && !convEnd) begin
      sar_q[RESULT_W[3:0] - tadCount_q] <= comparatorHigh;
    end
  end

  // result only moves on a completed conversion
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      result_q <= '0;
    end else if (convEnd) begin
      result_q <= {sar_q[RESULT_W-1:1], comparatorHigh};
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      doneFlag_q <= 1'b0;
    end else if (convEnd) begin
      doneFlag_q <= 1'b1;
    end else if (wrEn && paddr == adc_ctrl_pkg::ADDR_IRQ_STATUS &&
                 pwdata[adc_ctrl_pkg::DONE_IRQ_BIT]) begin
      doneFlag_q <= 1'b0;
    end
  end
  assign irq = doneFlag_q && doneMask_q;

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0;
    end else if (rdEn) begin
      prdata <= 32'h0;
      case (paddr)
        adc_ctrl_pkg::ADDR_CHANNEL_CONTROL: begin
          prdata[adc_ctrl_pkg::CHS_MSB:adc_ctrl_pkg::CHS_LSB] <= chanSel_q;
          prdata[adc_ctrl_pkg::GO_BIT]     <= goBusy_q;
          prdata[adc_ctrl_pkg::ENABLE_BIT] <= enable_q;
        end
        adc_ctrl_pkg::ADDR_CLOCK_CONFIG:
          prdata[adc_ctrl_pkg::CLKSEL_MSB:adc_ctrl_pkg::CLKSEL_LSB] <= clkSel_q;
        adc_ctrl_pkg::ADDR_RESULT_HIGH:
          prdata[1:0] <= result_q[RESULT_W-1:RESULT_W-2];
        adc_ctrl_pkg::ADDR_RESULT_LOW:
          prdata[7:0] <= result_q[7:0];
        adc_ctrl_pkg::ADDR_IRQ_STATUS:
          prdata[adc_ctrl_pkg::DONE_IRQ_BIT] <= doneFlag_q;
        adc_ctrl_pkg::ADDR_IRQ_MASK:
          prdata[adc_ctrl_pkg::DONE_IRQ_BIT] <= doneMask_q;
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // front end
  // ****************************************
  assign converterPower = enable_q;
  assign channelSelect  = chanSel_q;
  assign channelValid   = enable_q && chanOk(chanSel_q);
  // hold opens in the first conversion clock; no discharge phase exists,
  // so the capacitor keeps its charge into the next acquisition
  assign sampleHold     = (state_q == ST_CONVERT);
  assign bitTrial       = (state_q == ST_CONVERT) && tadCount_q != 4'h0;
  assign bitIndex       = RESULT_W[3:0] - tadCount_q;

  // ****************************************
  // checks
  // ****************************************
  a_end_loads_flag: assert property (@(posedge clk_sys)
    disable iff (!reset_n) convEnd |=> doneFlag_q && !goBusy_q)
    else $error("completion did not set flag or clear go");
  a_end_result: assert property (@(posedge clk_sys)
    disable iff (!reset_n) convEnd |=> result_q ==
      {$past(sar_q[RESULT_W-1:1]), $past(comparatorHigh)})
    else $error("result not loaded at completion");
  a_result_stable: assert property (@(posedge clk_sys)
    disable iff (!reset_n) !$past(convEnd) |-> $stable(result_q))
    else $error("result changed without completion");
  a_abort_keeps: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    swClearGo && state_q == ST_CONVERT |=> state_q == ST_ABORT && !goBusy_q)
    else $error("abort not taken");
  a_go_reads_busy: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    state_q == ST_CONVERT && !swClearGo && enable_q |-> goBusy_q)
    else $error("go bit low during conversion");
  a_flag_sticky: assert property (@(posedge clk_sys)
    disable iff (!reset_n) doneFlag_q && !wrEn |=> doneFlag_q)
    else $error("flag cleared without software");
  a_disable_idle: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    !enable_q |-> !converterPower ##1 (!goBusy_q && state_q != ST_CONVERT))
    else $error("disabled converter still busy");
  a_tad_count: assert property (@(posedge clk_sys)
    disable iff (!reset_n) convEnd |-> tadCount_q == 4'ha)
    else $error("conversion length not eleven clocks");
  a_reserved_chan: assert property (@(posedge clk_sys)
    disable iff (!reset_n) chanSel_q[4:3] == 2'b10 |-> !channelValid)
    else $error("unimplemented channel routed");
  c_complete: cover property (@(posedge clk_sys) disable iff (!reset_n)
    convEnd);
  c_abort: cover property (@(posedge clk_sys) disable iff (!reset_n)
    state_q == ST_ABORT ##1 state_q == ST_IDLE);
  c_irq: cover property (@(posedge clk_sys) disable iff (!reset_n) irq);
endmodule : adc_conversion_control
`default_nettype wire

// File: test/adc_front_end_model.sv
`default_nettype none
// ****************************************
// analog mux, hold capacitor and comparator
// ****************************************
module adc_front_end_model (
  // clock
  input  wire logic       clk_sys,
  // from the converter control
  input  wire logic       converterPower,
  input  wire logic       channelValid,
  input  wire logic       sampleHold,
  input  wire logic       bitTrial,
  input  wire logic [3:0] bitIndex,
  // level present on the selected node
  input  wire logic [9:0] level,
  // bit decision
  output logic            comparatorHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] charge = 10'h000;
  logic       shPrev = 1'b0;
  logic       junk   = 1'b0;
  // with nothing routed the old charge stays: no discharge
  always @(posedge clk_sys) begin
    shPrev <= sampleHold;
    junk   <= ~junk;
    if (sampleHold && !shPrev && channelValid && converterPower) begin
      charge <= level;
    end
  end
  // an ideal decision equals that bit of the held charge; outside a
  // trial the line toggles so no stale value can pass
  assign comparatorHigh = bitTrial ? charge[bitIndex] : junk;
endmodule : adc_front_end_model
`default_nettype wire

// File: test/adc_conversion_control_tb_top.sv
`default_nettype none
module adc_conversion_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] CTL = adc_ctrl_pkg::ADDR_CHANNEL_CONTROL;
  localparam logic [11:0] CLK = adc_ctrl_pkg::ADDR_CLOCK_CONFIG;
  localparam logic [11:0] RHI = adc_ctrl_pkg::ADDR_RESULT_HIGH;
  localparam logic [11:0] RLO = adc_ctrl_pkg::ADDR_RESULT_LOW;
  localparam logic [11:0] STA = adc_ctrl_pkg::ADDR_IRQ_STATUS;
  localparam logic [11:0] MSK = adc_ctrl_pkg::ADDR_IRQ_MASK;
  // ****************************************
  // signals
  // ****************************************
  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        rcOscTick, converterPower, channelValid, sampleHold;
  logic        bitTrial, comparatorHigh, irq, errSeen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  channelSelect;
  logic [3:0]  bitIndex;
  logic [9:0]  level;
  int          fail_count, checked, cycles, shCount, expRes, maskOn, rcCnt;
  adc_conversion_control adc_conversion_control_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .rcOscTick(rcOscTick),
    .converterPower(converterPower), .channelSelect(channelSelect),
    .channelValid(channelValid), .sampleHold(sampleHold),
    .bitTrial(bitTrial), .bitIndex(bitIndex),
    .comparatorHigh(comparatorHigh), .irq(irq));
  adc_front_end_model adc_front_end_model_i (
    .clk_sys(clk_sys), .converterPower(converterPower),
    .channelValid(channelValid), .sampleHold(sampleHold),
    .bitTrial(bitTrial), .bitIndex(bitIndex), .level(level),
    .comparatorHigh(comparatorHigh));
  // ****************************************
  // clock, rc oscillator, watchdog
  // ****************************************
  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;
  // rc tick every third cycle, so one rc conversion clock is 48 cycles
  always @(posedge clk_sys) begin
    cycles    <= cycles + 1;
    rcCnt     <= (rcCnt == 2) ? 0 : rcCnt + 1;
    rcOscTick <= (rcCnt == 2);
    if (sampleHold === 1'b1) shCount <= shCount + 1;
    if (cycles == 60000) begin
      fail_count = fail_count + 1;
      wrap_up();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic wrap_up();
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one idle edge first, so release and the next setup never collide
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd      = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input int exp, input string n);
    apb(1'b0, a, 32'h0);
    check(n, rd, 32'(exp));
  endtask : rdchk
  task automatic convert(input logic [4:0] channel_select, input logic [2:0] sel,
                         input int tad);
    int n;
    apb(1'b1, CLK, {25'h0, sel, 4'hf});
    rdchk(CLK, {sel, 4'h0}, "clock config");
    level <= 10'($urandom);
    apb(1'b1, CTL, {25'h0, channel_select, 2'h1});
    // settle time for the hold capacitor after a channel change
    repeat (20) @(posedge clk_sys);
    shCount = 0;
    apb(1'b1, CTL, {25'h0, channel_select, 2'h3});
    apb(1'b0, CTL, 32'h0);
    check("busy", rd[1], 1'b1);
    n = 0;
    while (rd[1] !== 1'b0 && n < 2000) begin
      apb(1'b0, CTL, 32'h0);
      n++;
    end
    check("control after", rd, {channel_select, 2'h1});
    if (channelValid === 1'b1) expRes = level;
    check("tad window", 32'(shCount > 10 * tad && shCount <= 11 * tad),
          32'h1);
    rdchk(RHI, expRes >> 8, "result high");
    rdchk(RLO, expRes & 8'hff, "result low");
    rdchk(STA, 1, "done flag");
    check("irq set", irq, 32'(maskOn));
    apb(1'b1, STA, 32'h1);
    rdchk(STA, 0, "flag cleared");
    check("irq clear", irq, 32'h0);
  endtask : convert
  // ****************************************
  // main sequence
  // ****************************************
  logic [2:0] sels [6] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int         tads [6] = '{8, 16, 32, 64, 48, 48};
  initial begin
    reset_n    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    rcOscTick  = 1'b0;
    level      = 10'h000;
    {fail_count, checked, cycles, shCount, expRes, maskOn, rcCnt} = '0;
    void'($urandom(35));
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    // results read 0 after reset by design choice
    for (int i = 0; i < 6; i++) rdchk(12'(4 * i), 0, "reset");
    rdchk(12'h018, 0, "unmapped");
    check("unmapped err", errSeen, 1'b1);
    // go together with enable is dropped, as enable is still low in that cycle, so go reads 0; bit 7 never sticks
    apb(1'b1, CTL, 32'hffffffff);
    rdchk(CTL, 32'h7d, "control ones");
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, CTL, 32'(c * 4 + 1));
      @(posedge clk_sys);
      check("chan valid", channelValid,
            32'(!(c == 8 || c == 9 || c / 8 == 2)));
      check("power on", converterPower, 32'h1);
      check("chan sel", channelSelect, 32'(c));
    end
    for (int i = 0; i < 6; i++) begin
      if (i == 3) begin
        apb(1'b1, MSK, 32'h1);
        maskOn = 1;
      end
      convert(i[0] ? 5'h18 | 5'($urandom) : 5'($urandom % 16 & 5'h17),
              sels[i], tads[i]);
    end
    // unrouted codes keep the previous charge
    convert(5'h12, 3'h1, 8);
    convert(5'h09, 3'h1, 8);
    // abort in mid-conversion
    level <= ~level;
    apb(1'b1, CTL, 32'h61);
    apb(1'b1, CTL, 32'h63);
    repeat (30) @(posedge clk_sys);
    apb(1'b1, CTL, 32'h61);
    rdchk(CTL, 32'h61, "aborted");
    apb(1'b1, CTL, 32'h63);
    rdchk(CTL, 32'h61, "go in gap");
    rdchk(RHI, expRes >> 8, "kept high");
    rdchk(RLO, expRes & 8'hff, "kept low");
    rdchk(STA, 0, "no flag");
    repeat (40) @(posedge clk_sys);
    apb(1'b1, RHI, 32'hff);
    apb(1'b1, RLO, 32'hff);
    rdchk(RHI, expRes >> 8, "write high");
    rdchk(RLO, expRes & 8'hff, "write low");
    convert(5'h1b, 3'h1, 8);
    apb(1'b1, CTL, 32'h0);
    @(posedge clk_sys);
    check("power off", converterPower, 32'h0);
    wrap_up();
  end
endmodule : adc_conversion_control_tb_top
`default_nettype wire
